// [common/umc_pkg.sv]
// Package: constants and types for the macrocell configuration block
package umc_pkg;
	localparam int NUM_CELLS = 8;
	localparam int NUM_TERMS = 8;
	localparam int NUM_INPUTS = 16;
	localparam int ROW_BITS = 2 * NUM_INPUTS;
	localparam int SIG_BITS = 64;
	localparam int LOWEST_CELL = 0;
	localparam int HIGHEST_CELL = NUM_CELLS - 1;
	localparam int OE_TERM = NUM_TERMS - 1;
	// Erased state: config cells float high, crosspoints open
	localparam logic CFG_ERASED = 1'h1;
	localparam logic XP_ERASED = 1'h0;
	localparam logic SEC_ERASED = 1'h0;
	localparam logic [63:0] SIG_ERASED = 64'hffffffffffffffff;
	localparam logic [31:0] ADDR_GLOBAL = 32'h00000000;
	localparam logic [31:0] ADDR_CELL = 32'h00000004;
	localparam logic [31:0] ADDR_SIG_LO = 32'h00000008;
	localparam logic [31:0] ADDR_SIG_HI = 32'h0000000c;
	localparam logic [31:0] ADDR_SEC = 32'h00000010;
	localparam logic [31:0] ADDR_ARRAY = 32'h00000100;
	localparam logic [31:0] ADDR_ARRAY_END = 32'h00000200;
	localparam int ROW_LSB = 2;
	localparam int ROW_W = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic register_allow_bit;
		logic family_select_bit;
		logic [NUM_CELLS-1:0] cell_mode_bit;
		logic [NUM_CELLS-1:0] output_polarity_bit;
	} umc_cfg_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} umc_wreq_t;
endpackage

// [verif/umc_board_model.sv]
// Board-side model: resolves the eight I/O pins between device and board
`timescale 1ns/1ps
module umc_board_model
	import umc_pkg::*;
(
	input wire logic [NUM_CELLS-1:0] io_out,
	input wire logic [NUM_CELLS-1:0] io_oe,
	input wire logic [NUM_CELLS-1:0] ext_val,
	output logic [NUM_CELLS-1:0] io_in
);
	// ==========
	// Pin resolution
	// The board drives a pin only where the device has let go of it
	assign io_in = (io_oe & io_out) | (~io_oe & ext_val);
endmodule

// [verif/umc_macrocells_bench.sv]
// Self-checking bench for the macrocell block
`timescale 1ns/1ps
module universal_macrocell_config_bench;
	import umc_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, clk_pin = 1'h0, oe_n_pin = 1'h0;
	logic [7:0] in_pin = 8'h00, ext_val = 8'h00, io_in, io_out, io_oe;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [34:0] rd_q[$];
	logic [1:0] wr_q[$];
	logic [34:0] e;
	int mismatches = 0, checks_done = 0;

	always #12.5 aclk = ~aclk;

	umc_macrocells DUT (.aclk(aclk), .aresetn(aresetn), .clk_pin(clk_pin),
		.oe_n_pin(oe_n_pin), .in_pin(in_pin), .io_in(io_in), .io_out(io_out),
		.io_oe(io_oe), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	umc_board_model board (.io_out(io_out), .io_oe(io_oe), .ext_val(ext_val), .io_in(io_in));

	// ==========
	// Compare tasks and verdict
	task automatic check_bus(input string n, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, ex, got);
		end
	endtask

	task automatic check_pin(input string n, input logic ex, input logic got);
		checks_done++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", n, ex, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// ==========
	// Bus master
	// Entry waits an edge so ready/valid strobes are never assigned twice in one step
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 1'h0;
		@(posedge aclk);
		wr_q.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				got = 1'h1;
				s_axi_bready <= 1'h0;
			end
		end
	endtask

	// Data check is skipped where chk is low; a refused read still returns a zero word
	task automatic axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
		input logic chk);
		logic got;
		got = 1'h0;
		@(posedge aclk);
		rd_q.push_back({chk, er, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!got) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				got = 1'h1;
				s_axi_rready <= 1'h0;
			end
		end
	endtask

	// ==========
	// Response monitor
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) begin
			e = rd_q.pop_front();
			check_bus("rresp", {30'h0, e[33:32]}, {30'h0, s_axi_rresp});
			if (e[34]) check_bus("rdata", e[31:0], s_axi_rdata);
		end
		if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0)
			check_bus("bresp", {30'h0, wr_q.pop_front()}, {30'h0, s_axi_bresp});
	end

	// Cell 0: term 0 is in_pin[0], terms 1..7 shorted to low by true plus complement
	task automatic prog_cell0(input logic [31:0] g, input logic [31:0] c);
		axi_write(ADDR_GLOBAL, g, RESP_OKAY);
		axi_write(ADDR_CELL, c, RESP_OKAY);
		for (int r = 0; r < 8; r++)
			axi_write(ADDR_ARRAY + 32'(4 * r), (r == 0) ? 32'h1 : 32'h3, RESP_OKAY);
	endtask

	task automatic settle();
		repeat (3) @(posedge aclk);
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		print_verdict();
	end

	// ==========
	// Main sequence
	initial begin
		void'($urandom(30));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		axi_read(ADDR_GLOBAL, 32'h3, RESP_OKAY, 1'h1);
		axi_read(ADDR_CELL, 32'h0000ffff, RESP_OKAY, 1'h1);
		axi_read(ADDR_SIG_HI, 32'hffffffff, RESP_OKAY, 1'h1);
		axi_write(ADDR_SIG_LO, 32'h5a5a1234, RESP_OKAY);
		axi_read(ADDR_SIG_LO, 32'h5a5a1234, RESP_OKAY, 1'h1);
		axi_read(32'h00000020, 32'h0, RESP_SLVERR, 1'h1);
		$display("test reset_and_map done");
		prog_cell0(32'h1, 32'h0000ff00);
		for (int i = 0; i < 8; i++) begin
			@(posedge aclk);
			in_pin <= 8'($urandom);
			ext_val <= 8'($urandom);
			settle();
			check_pin("comb_out", in_pin[0], io_out[0]);
			check_pin("comb_oe", 1'h1, io_oe[0]);
		end
		axi_write(ADDR_CELL, 32'h0, RESP_OKAY);
		settle();
		check_pin("inv_out", ~in_pin[0], io_out[0]);
		// Term 0 of cell 0 now reads its own feedback, which carries the enable pin
		axi_write(ADDR_ARRAY, 32'h00000004, RESP_OKAY);
		axi_write(ADDR_CELL, 32'h0000ff00, RESP_OKAY);
		repeat (4) begin
			@(posedge aclk);
			oe_n_pin <= 1'($urandom);
			settle();
			check_pin("oe_as_input", oe_n_pin, io_out[0]);
		end
		// Cells 1 and 2 as inputs: cell 1 feedback carries the board level on pin 2
		axi_write(ADDR_ARRAY, 32'h00000040, RESP_OKAY);
		axi_write(ADDR_CELL, 32'h0000ff06, RESP_OKAY);
		repeat (4) begin
			@(posedge aclk);
			ext_val <= 8'($urandom);
			settle();
			check_pin("adjacent_in", ext_val[2], io_out[0]);
			check_pin("input_oe", 1'h0, io_oe[1]);
		end
		$display("test combinatorial done");
		prog_cell0(32'h2, 32'h0000ff00);
		in_pin <= 8'h01;
		oe_n_pin <= 1'h0;
		settle();
		check_pin("reg_low", 1'h0, io_out[0]);
		check_pin("reg_oe_on", 1'h1, io_oe[0]);
		@(posedge aclk);
		oe_n_pin <= 1'h1;
		settle();
		check_pin("reg_oe_off", 1'h0, io_oe[0]);
		for (int k = 0; k < 2; k++) begin
			@(posedge aclk);
			clk_pin <= 1'h1;
			settle();
			check_pin("reg_cap", ~k[0], io_out[0]);
			@(posedge aclk);
			clk_pin <= 1'h0;
			in_pin <= 8'h00;
			settle();
			check_pin("reg_hold", ~k[0], io_out[0]);
		end
		$display("test registered done");
		axi_write(ADDR_SEC, 32'h1, RESP_OKAY);
		axi_read(ADDR_ARRAY, 32'h0, RESP_SLVERR, 1'h0);
		axi_write(ADDR_ARRAY, 32'h0, RESP_SLVERR);
		axi_read(ADDR_SIG_LO, 32'h5a5a1234, RESP_OKAY, 1'h1);
		axi_read(ADDR_SEC, 32'h1, RESP_OKAY, 1'h1);
		axi_write(ADDR_SEC, 32'h2, RESP_OKAY);
		axi_read(ADDR_SEC, 32'h0, RESP_OKAY, 1'h1);
		axi_read(ADDR_GLOBAL, 32'h3, RESP_OKAY, 1'h1);
		axi_read(ADDR_ARRAY, 32'h0, RESP_OKAY, 1'h1);
		$display("test security done");
		settle();
		print_verdict();
	end
endmodule

// [verilog/umc_macrocells.sv]
// Eight-macrocell sum-of-products device with AXI4-Lite programming port
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module umc_macrocells
	import umc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_pin,
	input wire logic oe_n_pin,
	input wire logic [NUM_CELLS-1:0] in_pin,
	input wire logic [NUM_CELLS-1:0] io_in,
	output logic [NUM_CELLS-1:0] io_out,
	output logic [NUM_CELLS-1:0] io_oe,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int NROWS = NUM_CELLS * NUM_TERMS;

	typedef struct packed {
		umc_cfg_t cfg;
		logic secured;
		logic [SIG_BITS-1:0] sig;
		logic [NUM_CELLS-1:0] ff;
		logic clk_prev;
		logic aw_held;
		logic w_held;
		umc_wreq_t wreq;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} umc_state_t;

	// Nonvolatile contents start as an erased part; reset leaves them alone
	localparam umc_state_t STATE_ERASED = '{cfg: {$bits(umc_cfg_t){CFG_ERASED}},
		secured: SEC_ERASED, sig: SIG_ERASED, default: '0};
	umc_state_t state_reg = STATE_ERASED;
	umc_state_t state_next;
	// Fuse array sits outside the struct: 64 rows of 32 crosspoints
	logic [ROW_BITS-1:0] array_reg [NROWS] = '{default: {ROW_BITS{XP_ERASED}}};

	// ==========================================================
	// Array and macrocell datapath
	logic [NUM_INPUTS-1:0] arr_in;
	logic [ROW_BITS-1:0] lit;
	logic [NROWS-1:0] pterm;
	logic [NUM_CELLS-1:0] fb;
	logic [NUM_CELLS-1:0] sum;
	logic [NUM_CELLS-1:0] d_val;
	logic clk_rise;
	logic reg_dev;

	assign reg_dev = ~state_reg.cfg.register_allow_bit;
	assign clk_rise = clk_pin & ~state_reg.clk_prev;

	always_comb begin
		for (int k = 0; k < NUM_INPUTS; k++) begin
			lit[2*k] = arr_in[k];
			lit[2*k+1] = ~arr_in[k];
		end
	end

	generate
		for (genvar r = 0; r < NROWS; r++) begin : g_row
			// Open crosspoints mask out; empty row is high, x and ~x row is low
			assign pterm[r] = &(lit | ~array_reg[r]);
		end
		for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
			logic mode;
			logic fb_sel;
			logic io_cfg;
			logic [NUM_TERMS-1:0] terms;
			logic adj;
			assign mode = state_reg.cfg.cell_mode_bit[c];
			assign terms = pterm[c*NUM_TERMS +: NUM_TERMS];
			// Combinatorial I/O whenever family is set with mode 1
			assign io_cfg = state_reg.cfg.family_select_bit & mode;
			// Seven terms to the OR in I/O mode, eighth drives the enable
			assign sum[c] = io_cfg ? |terms[OE_TERM-1:0] : |terms;
			assign d_val[c] = sum[c] ^ ~state_reg.cfg.output_polarity_bit[c];
			// Feedback select: low picks the adjacent pin, high the unused path
			if (c == LOWEST_CELL) begin : g_lo
				assign adj = oe_n_pin;
				assign fb_sel = ~state_reg.cfg.register_allow_bit;
			end else if (c == HIGHEST_CELL) begin : g_hi
				assign adj = clk_pin;
				assign fb_sel = ~state_reg.cfg.register_allow_bit;
			end else begin : g_mid
				assign adj = io_in[c+1];
				assign fb_sel = state_reg.cfg.family_select_bit
					| ~state_reg.cfg.cell_mode_bit[c+1];
			end
			always_comb begin
				io_out[c] = 1'b0;
				io_oe[c] = 1'b0;
				fb[c] = 1'b0;
				if (reg_dev && !state_reg.cfg.family_select_bit) begin
					io_oe[c] = 1'b0;
				end else if (reg_dev && !mode) begin
					io_out[c] = state_reg.ff[c];
					io_oe[c] = ~oe_n_pin;
					fb[c] = ~state_reg.ff[c];
				end else if (io_cfg) begin
					io_out[c] = d_val[c];
					io_oe[c] = terms[OE_TERM];
					fb[c] = io_in[c];
				end else if (!mode) begin
					io_out[c] = d_val[c];
					io_oe[c] = 1'b1;
					fb[c] = fb_sel ? 1'b0 : adj;
				end else begin
					fb[c] = adj;
				end
			end
		end
	endgenerate

	// Array inputs interleave dedicated pins and cell feedback
	always_comb begin
		for (int k = 0; k < NUM_CELLS; k++) begin
			arr_in[2*k] = in_pin[k];
			arr_in[2*k+1] = fb[k];
		end
	end

	// ==========================================================
	// Register bus
	logic [31:0] waddr;
	logic [31:0] raddr;
	logic [ROW_W-1:0] wrow;
	logic [ROW_W-1:0] rrow;
	logic w_array;
	logic r_array;
	logic do_write;

	assign s_axi_awready = ~state_reg.aw_held & ~state_reg.bvalid;
	assign s_axi_wready = ~state_reg.w_held & ~state_reg.bvalid;
	assign s_axi_arready = ~state_reg.rvalid;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp = state_reg.rresp;
	assign s_axi_rdata = state_reg.rdata;
	assign waddr = state_reg.wreq.addr;
	assign raddr = s_axi_araddr;
	assign wrow = waddr[ROW_LSB +: ROW_W];
	assign rrow = raddr[ROW_LSB +: ROW_W];
	assign w_array = waddr >= ADDR_ARRAY && waddr < ADDR_ARRAY_END;
	assign r_array = raddr >= ADDR_ARRAY && raddr < ADDR_ARRAY_END;
	assign do_write = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;

	always_comb begin
		state_next = state_reg;
		state_next.clk_prev = clk_pin;
		if (clk_rise && reg_dev) begin
			state_next.ff = d_val;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			state_next.aw_held = 1'b1;
			state_next.wreq.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_next.w_held = 1'b1;
			state_next.wreq.data = s_axi_wdata;
			state_next.wreq.strb = s_axi_wstrb;
		end
		if (do_write) begin
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			if (waddr == ADDR_SEC) begin
				if (state_reg.wreq.data[1]) begin
					// Bulk erase returns everything to the unprogrammed state
					state_next.cfg = {$bits(umc_cfg_t){CFG_ERASED}};
					state_next.secured = SEC_ERASED;
					state_next.sig = SIG_ERASED;
				end else if (state_reg.wreq.data[0]) begin
					state_next.secured = 1'b1;
				end
			end else if (state_reg.secured) begin
				state_next.bresp = RESP_SLVERR;
			end else if (waddr == ADDR_GLOBAL) begin
				state_next.cfg.register_allow_bit = state_reg.wreq.data[0];
				state_next.cfg.family_select_bit = state_reg.wreq.data[1];
			end else if (waddr == ADDR_CELL) begin
				state_next.cfg.cell_mode_bit = state_reg.wreq.data[7:0];
				state_next.cfg.output_polarity_bit = state_reg.wreq.data[15:8];
			end else if (waddr == ADDR_SIG_LO) begin
				state_next.sig[31:0] = state_reg.wreq.data;
			end else if (waddr == ADDR_SIG_HI) begin
				state_next.sig[63:32] = state_reg.wreq.data;
			end else if (!w_array) begin
				state_next.bresp = RESP_SLVERR;
			end
		end
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = RESP_OKAY;
			state_next.rdata = 32'h00000000;
			if (raddr == ADDR_SIG_LO) begin
				state_next.rdata = state_reg.sig[31:0];
			end else if (raddr == ADDR_SIG_HI) begin
				state_next.rdata = state_reg.sig[63:32];
			end else if (raddr == ADDR_SEC) begin
				state_next.rdata = {31'h0, state_reg.secured};
			end else if (state_reg.secured) begin
				state_next.rresp = RESP_SLVERR;
			end else if (raddr == ADDR_GLOBAL) begin
				state_next.rdata = {30'h0, state_reg.cfg.family_select_bit,
					state_reg.cfg.register_allow_bit};
			end else if (raddr == ADDR_CELL) begin
				state_next.rdata = {16'h0, state_reg.cfg.output_polarity_bit,
					state_reg.cfg.cell_mode_bit};
			end else if (r_array) begin
				state_next.rdata = array_reg[rrow];
			end else begin
				state_next.rresp = RESP_SLVERR;
			end
		end else if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (!aresetn) begin
			// Reset models power-up: flip-flops low, stored fuses kept
			state_next.ff = '0;
			state_next.clk_prev = 1'b0;
			state_next.aw_held = 1'b0;
			state_next.w_held = 1'b0;
			state_next.bvalid = 1'b0;
			state_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		state_reg <= state_next;
	end

	always_ff @(posedge aclk) begin
		if (aresetn && do_write && w_array && !state_reg.secured) begin
			array_reg[wrow] <= state_reg.wreq.data;
		end else if (aresetn && do_write && waddr == ADDR_SEC && state_reg.wreq.data[1]) begin
			for (int r = 0; r < NROWS; r++) begin
				array_reg[r] <= {ROW_BITS{XP_ERASED}};
			end
		end
	end

	// ==========================================================
	// Checks
	flop_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_rise && reg_dev) |=> state_reg.ff == $past(d_val))
		else $error("cell flop missed clock edge");
	reg_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(reg_dev && state_reg.cfg.family_select_bit && !state_reg.cfg.cell_mode_bit[0])
		|-> io_oe[0] == ~oe_n_pin)
		else $error("registered enable wrong");
	input_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!reg_dev && !state_reg.cfg.family_select_bit && state_reg.cfg.cell_mode_bit[3])
		|-> !io_oe[3])
		else $error("input cell drives pin");
	secure_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && state_reg.secured && waddr != ADDR_SEC) |=> s_axi_bresp == RESP_SLVERR)
		else $error("secured write accepted");
	sig_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && raddr == ADDR_SIG_LO)
		|=> s_axi_rresp == RESP_OKAY && s_axi_rdata == $past(state_reg.sig[31:0]))
		else $error("signature not readable");
	powerup_low_a: assert property (@(posedge aclk)
		$rose(aresetn) |-> state_reg.ff == '0)
		else $error("flops not low after reset");
	polarity_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!reg_dev && !state_reg.cfg.cell_mode_bit[5])
		|-> (io_out[5] ^ sum[5]) == ~state_reg.cfg.output_polarity_bit[5])
		else $error("polarity wrong");
	io_fb_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.cfg.family_select_bit && state_reg.cfg.cell_mode_bit[2])
		|-> fb[2] == io_in[2] && io_oe[2] == pterm[2*NUM_TERMS+OE_TERM])
		else $error("io cell feedback wrong");
	reg_feedback_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(reg_dev && state_reg.cfg.family_select_bit && !state_reg.cfg.cell_mode_bit[4])
		|-> fb[4] != io_out[4])
		else $error("registered feedback not inverted");
	clk_input_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!reg_dev && !state_reg.cfg.cell_mode_bit[7]) |-> fb[7] == clk_pin)
		else $error("clock pin not routed as input");
endmodule
